// *** hdl/srm_sysref_sync.sv ***
// reference capture, skip counter, window monitor, latency pipes and register slave
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module srm_sysref_sync #(
   parameter int DATA_W = 14,
   parameter int N_TAPS = 15
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [15:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [15:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              sysref_pos,
   input  wire logic              sysref_neg,
   input  wire logic [N_TAPS-1:0] setup_taps,
   input  wire logic [N_TAPS-1:0] hold_taps,
   input  wire logic [DATA_W-1:0] adc_sample,
   output logic [DATA_W-1:0]      core_sample,
   output logic [DATA_W-1:0]      total_sample,
   output logic [3:0]             sync_pulse,
   output logic [3:0]             lane_rate_sel,
   output logic [11:0]            link_params
);
   localparam int DEPTH = 1024;

   //---------------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------------
   srm_pkg::srm_ctrl_t    ctrl_q, ctrl_d;
   srm_pkg::srm_status_t  stat_q, stat_d;
   srm_pkg::srm_state_t   st_q, st_d;
   logic [4:0]            skip_q, skip_d, left_q, left_d;
   logic [2:0]            mode_q, mode_d;
   logic [3:0]            lrate_q, lrate_d, sync_q, sync_d;
   logic [7:0]            quick_q, quick_d;
   logic [11:0]           lpar_q, lpar_d;
   logic                  ref_q, ref_prev_q, ref_d;
   logic [N_TAPS-1:0]     stap_q, htap_q;
   logic                  aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [11:0]           aw_idx_q, aw_idx_d;
   logic [31:0]           wdat_q, wdat_d, rdata_q, rdata_d;
   logic                  bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]            bresp_q, bresp_d, rresp_q, rresp_d;
   logic                  arready_q, arready_d;
   logic                  ev, act, wr_now, ar_take, rd_status, hit;
   logic [3:0]            su_cnt, ho_cnt;
   logic [9:0]            lat_tot;
   logic [11:0]           ar_idx;
   logic [DATA_W-1:0]     mem [DEPTH];
   logic [9:0]            wr_q, rd_core, rd_tot;
   logic [DATA_W-1:0]     core_q, tot_q;

   // number of phase taps that agree with the newly sampled level
   function automatic logic [3:0] agree(input logic [N_TAPS-1:0] t, input logic lvl);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < N_TAPS; i++)
         n = n + {4'h0, t[i] == lvl};
      agree = (n > 5'h0f) ? 4'hf : n[3:0];
   endfunction

   // margin verdict from the two fields
   function automatic logic [1:0] judge(input logic [3:0] h, input logic [3:0] s);
      if (h == 4'h0 && s == 4'h0)
         judge = srm_pkg::VERD_EITHER;
      else if (h == 4'h0 && s < srm_pkg::MID_CODE)
         judge = srm_pkg::VERD_SETUP;
      else if (s == 4'h0 && h > srm_pkg::MID_CODE)
         judge = srm_pkg::VERD_HOLD;
      else
         judge = srm_pkg::VERD_OK;
   endfunction

   //---------------------------------------------------------------------------
   // reference capture and latency selection
   //---------------------------------------------------------------------------
   // falling clock phase arrives pre-sampled from the front end on sysref_neg
   always_comb
   begin
      ref_d   = ctrl_q.clk_fall ? sysref_neg : sysref_pos;
      ev      = ctrl_q.pol_fall ? (ref_prev_q & ~ref_q)
                                : (~ref_prev_q & ref_q);
      act     = ev && st_q == srm_pkg::SRM_ARMED && left_q == 5'h00;
      su_cnt  = agree(stap_q, ref_q);
      ho_cnt  = agree(htap_q, ref_q);
      case (mode_q)
         3'd0:    lat_tot = srm_pkg::LAT_FULL;
         3'd1:    lat_tot = srm_pkg::LAT_HB1;
         3'd2:    lat_tot = srm_pkg::LAT_HB2;
         3'd3:    lat_tot = srm_pkg::LAT_HB3;
         default: lat_tot = srm_pkg::LAT_HB4;
      endcase
      // read one early because the output register adds a cycle
      rd_core = wr_q - 10'(srm_pkg::ADC_LAT - 1);
      rd_tot  = wr_q - (lat_tot - 10'd1);
   end

   //---------------------------------------------------------------------------
   // register slave and capture engine next state
   //---------------------------------------------------------------------------
   always_comb
   begin
      ctrl_d = ctrl_q;
      skip_d = skip_q;
      mode_d = mode_q;
      lrate_d = lrate_q;
      quick_d = quick_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      arready_d = arready_q;
      ar_idx = s_axi_araddr[13:2];
      hit = 1'b1;
      // address and data may come in either order; a held item is kept
      aw_have_d = aw_have_q | s_axi_awvalid;
      aw_idx_d  = aw_have_q ? aw_idx_q : s_axi_awaddr[13:2];
      w_have_d  = w_have_q | s_axi_wvalid;
      wdat_d    = w_have_q ? wdat_q : s_axi_wdata;
      wr_now = aw_have_q && w_have_q && !bvalid_q;
      if (wr_now)
      begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = srm_pkg::RESP_OKAY;
         case (aw_idx_q)
            srm_pkg::IDX_CTRL:     ctrl_d = wdat_q[7:0];
            srm_pkg::IDX_SKIP:     skip_d = (wdat_q[4:0] > srm_pkg::SKIP_MAX)
                                          ? srm_pkg::SKIP_MAX : wdat_q[4:0];
            srm_pkg::IDX_LAT_MODE: mode_d = wdat_q[2:0];
            srm_pkg::IDX_LANERATE: lrate_d = wdat_q[7:4];
            srm_pkg::IDX_QUICK:    quick_d = wdat_q[7:0];
            srm_pkg::IDX_STATUS, srm_pkg::IDX_LAT_READ,
            srm_pkg::IDX_LINKPAR:  bresp_d = srm_pkg::RESP_OKAY;
            default:               bresp_d = srm_pkg::RESP_SLVERR;
         endcase
      end
      else if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      // reads answer one cycle after the address is taken
      ar_take = s_axi_arvalid && arready_q;
      rd_status = ar_take && ar_idx == srm_pkg::IDX_STATUS;
      if (ar_take)
      begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         case (ar_idx)
            srm_pkg::IDX_CTRL:     rdata_d = {24'h0, ctrl_q};
            srm_pkg::IDX_SKIP:     rdata_d = {27'h0, skip_q};
            srm_pkg::IDX_STATUS:   rdata_d = {21'h0, stat_q};
            srm_pkg::IDX_LAT_MODE: rdata_d = {29'h0, mode_q};
            srm_pkg::IDX_LAT_READ: rdata_d = {6'h0, 10'(srm_pkg::ADC_LAT), 6'h0, lat_tot};
            srm_pkg::IDX_LANERATE: rdata_d = {24'h0, lrate_q, 4'h0};
            srm_pkg::IDX_QUICK:    rdata_d = {24'h0, quick_q};
            srm_pkg::IDX_LINKPAR:  rdata_d = {20'h0, lpar_q};
            default:
            begin
               rdata_d = 32'h0;
               hit = 1'b0;
            end
         endcase
         rresp_d = hit ? srm_pkg::RESP_OKAY : srm_pkg::RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
      begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end
      // quick configuration decode, only the one-lane four-converter code is known
      lpar_d = (quick_q == srm_pkg::QUICK_L1M4F8)
             ? {srm_pkg::Q13_LANES, srm_pkg::Q13_CONV, srm_pkg::Q13_OCTETS}
             : 12'h000;
      // capture engine: re-arming reloads the skip count
      st_d   = ctrl_q.enable ? srm_pkg::SRM_ARMED : srm_pkg::SRM_OFF;
      left_d = left_q;
      sync_d = 4'h0;
      stat_d = stat_q;
      if (st_q == srm_pkg::SRM_OFF)
         left_d = skip_q;
      else if (ev && left_q != 5'h00)
         left_d = left_q - 5'h01;
      else if (act)
         left_d = skip_q;
      // read clears the captured flag, a new capture in that cycle wins
      if (rd_status)
         stat_d.captured = 1'b0;
      if (act)
      begin
         sync_d          = ctrl_q.target;
         stat_d.setup    = su_cnt;
         stat_d.hold     = ho_cnt;
         stat_d.verdict  = judge(ho_cnt, su_cnt);
         stat_d.captured = 1'b1;
      end
   end

   //---------------------------------------------------------------------------
   // registers
   //---------------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= srm_pkg::CTRL_RST;
         skip_q <= 5'h00;
         left_q <= 5'h00;
         mode_q <= 3'h0;
         lrate_q <= srm_pkg::LRATE_RST;
         quick_q <= srm_pkg::QUICK_RST;
         lpar_q <= 12'h000;
         st_q <= srm_pkg::SRM_OFF;
         stat_q <= '0;
         sync_q <= 4'h0;
         ref_q <= 1'b0;
         ref_prev_q <= 1'b0;
         stap_q <= '0;
         htap_q <= '0;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_idx_q <= 12'h000;
         wdat_q <= 32'h0;
         bvalid_q <= 1'b0;
         bresp_q <= srm_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= srm_pkg::RESP_OKAY;
         rdata_q <= 32'h0;
         arready_q <= 1'b1;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         skip_q <= skip_d;
         left_q <= left_d;
         mode_q <= mode_d;
         lrate_q <= lrate_d;
         quick_q <= quick_d;
         lpar_q <= lpar_d;
         st_q <= st_d;
         stat_q <= stat_d;
         sync_q <= sync_d;
         ref_q <= ref_d;
         ref_prev_q <= ref_q;
         stap_q <= setup_taps;   // aligned with ref_q
         htap_q <= hold_taps;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         aw_idx_q <= aw_idx_d;
         wdat_q <= wdat_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         arready_q <= arready_d;
      end
   end

   // sample delay ring; contents are not reset, outputs settle after the fill
   always_ff @(posedge aclk)
   begin
      mem[wr_q] <= adc_sample;
      core_q    <= mem[rd_core];
      tot_q     <= mem[rd_tot];
      wr_q      <= aresetn ? wr_q + 10'd1 : 10'd0;
   end

   //---------------------------------------------------------------------------
   // outputs
   //---------------------------------------------------------------------------
   assign s_axi_awready = ~aw_have_q;
   assign s_axi_wready  = ~w_have_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign core_sample   = core_q;
   assign total_sample  = tot_q;
   assign sync_pulse    = sync_q;
   assign lane_rate_sel = lrate_q;
   assign link_params   = lpar_q;

   //---------------------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------------------
   logic [9:0] fill_q;
   always_ff @(posedge aclk)
      fill_q <= !aresetn ? 10'd0 : (fill_q == 10'd1023 ? fill_q : fill_q + 10'd1);

   a_core_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      fill_q == 10'd1023 |-> core_q == $past(adc_sample, 28))
      else $error("core delay is not 28 cycles");
   a_full_bw_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      fill_q == 10'd1023 && mode_q == 3'd0 && $past(mode_q, 44) == 3'd0
      |-> tot_q == $past(adc_sample, 44))
      else $error("full bandwidth latency is not 44");
   a_act_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      act |=> sync_q == $past(ctrl_q.target) && stat_q.captured)
      else $error("acted event gave no realign pulse");
   a_skip_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      ev && st_q == srm_pkg::SRM_ARMED && left_q != 5'h00
      |=> sync_q == 4'h0 && left_q == $past(left_q) - 5'h01)
      else $error("skipped event was not counted down");
   a_edge_pick: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_q.pol_fall && $rose(ref_q) && !$rose(ctrl_q.pol_fall) |-> ev)
      else $error("rising transition not detected");
   a_sticky_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      stat_q.captured && !rd_status |=> stat_q.captured)
      else $error("captured flag dropped without a read");
   a_setup_verdict: assert property (@(posedge aclk) disable iff (!aresetn)
      stat_q.captured && stat_q.hold == 4'h0 && stat_q.setup != 4'h0 && stat_q.setup < 4'h8
      |-> stat_q.verdict == srm_pkg::VERD_SETUP)
      else $error("setup violation not flagged");
   a_hold_verdict: assert property (@(posedge aclk) disable iff (!aresetn)
      stat_q.captured && stat_q.setup == 4'h0 && stat_q.hold > 4'h8
      |-> stat_q.verdict == srm_pkg::VERD_HOLD)
      else $error("hold violation not flagged");
   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !bvalid_q
      |=> ##1 bvalid_q)
      else $error("write answer missing");
   a_quick_decode: assert property (@(posedge aclk) disable iff (!aresetn)
      quick_q == 8'h13 && $past(quick_q) == 8'h13 && $past(aresetn) |-> lpar_q == 12'h148)
      else $error("quick configuration misdecoded");
endmodule

// *** hdl/srm_pkg.sv ***
// constants, register map and carrier types of the reference capture block
//------------------------------------------------------------------------------
// Overview of operation
// - converter core delays every sample by exactly 28 encode clocks.
// - total latency follows mode: 44 full bandwidth up to 587 with four half-bands.
// - acted reference event realigns clock divider, downconverters, monitor and link.
// - polarity bit selects rising or falling reference transition as the event.
// - edge bit selects sampling on rising or falling converter clock edge.
// - a programmed count of events, up to 16, is skipped before acting.
// - setup field reports reference state at phases ahead of the clock edge.
// - hold field reports reference state at phases after the clock edge.
// - status register 0x128 holds timing status and a captured indication.
// - hold result sits in bits 7:4, setup result in bits 3:0.
// - hold zero with setup 0x1 to 0x7 means possible setup violation.
// - setup zero with hold 0x9 to 0xF means possible hold violation.
// - setup 0x8 with hold 0x0 to 0x8 means clean timing, best hold margin.
// - hold 0x8 with setup 0x9 to 0xF means clean, best combined margin.
// - both fields zero means possible setup or hold violation.
// - quick configuration 0x13 selects one lane, four converters, eight octets.
//------------------------------------------------------------------------------
package srm_pkg;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_CTRL     = 12'h120;
   localparam logic [11:0] IDX_SKIP     = 12'h121;
   localparam logic [11:0] IDX_STATUS   = 12'h128;
   localparam logic [11:0] IDX_LAT_MODE = 12'h130;
   localparam logic [11:0] IDX_LAT_READ = 12'h131;
   localparam logic [11:0] IDX_LANERATE = 12'h56e;
   localparam logic [11:0] IDX_QUICK    = 12'h570;
   localparam logic [11:0] IDX_LINKPAR  = 12'h571;
   // resets and field limits
   localparam logic [7:0]  CTRL_RST     = 8'hf0;
   localparam logic [4:0]  SKIP_MAX     = 5'h10;
   localparam logic [7:0]  QUICK_RST    = 8'h13;
   localparam logic [3:0]  LRATE_RST    = 4'h1;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // latency figures in encode clocks
   localparam int          ADC_LAT      = 28;
   localparam logic [9:0]  LAT_FULL     = 10'd44;
   localparam logic [9:0]  LAT_HB1      = 10'd109;
   localparam logic [9:0]  LAT_HB2      = 10'd175;
   localparam logic [9:0]  LAT_HB3      = 10'd320;
   localparam logic [9:0]  LAT_HB4      = 10'd587;
   // quick configuration decode
   localparam logic [7:0]  QUICK_L1M4F8 = 8'h13;
   localparam logic [3:0]  Q13_LANES    = 4'h1;
   localparam logic [3:0]  Q13_CONV     = 4'h4;
   localparam logic [3:0]  Q13_OCTETS   = 4'h8;
   // monitor verdict codes and status field positions
   localparam logic [1:0]  VERD_OK      = 2'h0;
   localparam logic [1:0]  VERD_SETUP   = 2'h1;
   localparam logic [1:0]  VERD_HOLD    = 2'h2;
   localparam logic [1:0]  VERD_EITHER  = 2'h3;
   localparam logic [3:0]  MID_CODE     = 4'h8;
   localparam int          ST_CAPT_BIT  = 8;
   localparam int          ST_VERD_LSB  = 9;

   typedef struct packed {
      logic [3:0] target;   // link, monitor, ddc, clock divider
      logic       rsvd;
      logic       clk_fall; // sample on falling clock phase
      logic       pol_fall; // falling transition is the event
      logic       enable;
   } srm_ctrl_t;

   typedef struct packed {
      logic [1:0] verdict;
      logic       captured;
      logic [3:0] hold;
      logic [3:0] setup;
   } srm_status_t;

   typedef enum logic {SRM_OFF, SRM_ARMED} srm_state_t;
endpackage

// *** test/srm_ref_gen.sv ***
// reference pulse generator standing in for the system clock chip
`timescale 1ns/1ps
module srm_ref_gen (
   input  wire logic   aclk,
   input  wire logic   use_neg,
   output logic        sysref_pos,
   output logic        sysref_neg,
   output logic [14:0] setup_taps,
   output logic [14:0] hold_taps
);
   //---------------------------------------------------------------
   // level driver
   //---------------------------------------------------------------
   // both views start low; the unselected view stands still
   initial
   begin
      sysref_pos = 1'b0;
      sysref_neg = 1'b0;
      setup_taps = 15'h0;
      hold_taps  = 15'h0;
   end
   // ns and nh taps agree with the new level, the rest show the old one
   task automatic drive(input logic lvl, input int ns, input int nh);
      logic [14:0] ms;
      logic [14:0] mh;
      ms = 15'((1 << ns) - 1);
      mh = 15'((1 << nh) - 1);
      @(posedge aclk);
      if (use_neg)
         sysref_neg <= lvl;
      else
         sysref_pos <= lvl;
      setup_taps <= lvl ? ms : ~ms;
      hold_taps  <= lvl ? mh : ~mh;
   endtask
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the reference capture block
`timescale 1ns/1ps
module tb_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf, sync_pulse, lane_rate_sel, last_pulse;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, use_neg = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        sysref_pos, sysref_neg;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [14:0] setup_taps, hold_taps;
   logic [13:0] adc_sample = 14'h0, core_sample, total_sample;
   logic [11:0] link_params;
   int          mismatches = 0, checked = 0, pulses = 0, cyc = 0;

   srm_sysref_sync u_srm_sysref_sync (.*);
   srm_ref_gen u_srm_ref_gen (.aclk(aclk), .use_neg(use_neg), .sysref_pos(sysref_pos),
      .sysref_neg(sysref_neg), .setup_taps(setup_taps), .hold_taps(hold_taps));

   //---------------------------------------------------------------
   // clock, sample ramp, pulse monitor and watchdog
   //---------------------------------------------------------------
   always #25 aclk = ~aclk;
   // the ramp makes any pipeline depth error show as a value offset
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      adc_sample <= cyc[13:0];
      if (sync_pulse !== 4'h0)
      begin
         pulses <= pulses + 1;
         last_pulse <= sync_pulse;
      end
      if (cyc == 20000)
      begin
         mismatches++;
         close_out();
      end
   end
   // one comparison, counted
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // write one register word, both channels offered together
   task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] erp);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {2'b00, idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            chk(32'(s_axi_bresp), 32'(erp));
            done = 1'b1;
         end
      end
      s_axi_bready <= 1'b0;
   endtask
   // read one register word and compare data and response
   task automatic rc(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] erp);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            chk(s_axi_rdata, exp);
            chk(32'(s_axi_rresp), 32'(erp));
            done = 1'b1;
         end
      end
      s_axi_rready <= 1'b0;
   endtask
   // inactive level first, then the event level with its tap pattern
   task automatic ev(input logic pf, input int ns, input int nh);
      u_srm_ref_gen.drive(pf, 0, 0);
      repeat (4) @(posedge aclk);
      u_srm_ref_gen.drive(~pf, ns, nh);
      repeat (6) @(posedge aclk);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   //---------------------------------------------------------------
   // test sequence
   //---------------------------------------------------------------
   initial
   begin
      int lat [5] = '{44, 109, 175, 320, 587};
      int skips [5] = '{0, 1, 2, 16, 3};
      int ns [5] = '{3, 0, 8, 11, 0};
      int nh [5] = '{0, 10, 5, 8, 0};
      logic [1:0] verd [5] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h3};
      logic [3:0] mask [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
      logic [31:0] st;
      int p0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rc(srm_pkg::IDX_CTRL, 32'hf0, 2'h0);
      rc(srm_pkg::IDX_QUICK, 32'h13, 2'h0);
      chk(32'(link_params), 32'h148);
      rc(12'h200, 32'h0, 2'h2);
      wr(12'h200, 32'h1, 2'h2);
      wr(srm_pkg::IDX_LANERATE, 32'h50, 2'h0);
      chk(32'(lane_rate_sel), 32'h5);
      wr(srm_pkg::IDX_LANERATE, 32'h10, 2'h0);
      chk(32'(lane_rate_sel), 32'h1);
      // the ring is not reset, so let a full depth of samples pass
      for (int m = 0; m < 5; m++)
      begin
         wr(srm_pkg::IDX_LAT_MODE, 32'(m), 2'h0);
         repeat (1030) @(posedge aclk);
         #1;
         chk(32'(core_sample), 32'(14'(adc_sample - 14'd28)));
         chk(32'(total_sample), 32'(14'(adc_sample - 14'(lat[m]))));
         rc(srm_pkg::IDX_LAT_READ, {6'h0, 10'd28, 6'h0, 10'(lat[m])}, 2'h0);
      end
      for (int k = 0; k < 5; k++)
      begin
         use_neg <= k[1];
         wr(srm_pkg::IDX_CTRL, {24'h0, mask[k], 1'b0, k[1], k[0], 1'b0}, 2'h0);
         wr(srm_pkg::IDX_SKIP, 32'(skips[k]), 2'h0);
         p0 = pulses;
         ev(k[0], 1, 1);
         chk(32'(pulses - p0), 32'h0);
         wr(srm_pkg::IDX_CTRL, {24'h0, mask[k], 1'b0, k[1], k[0], 1'b1}, 2'h0);
         for (int e = 0; e < skips[k]; e++)
            ev(k[0], ns[k], nh[k]);
         chk(32'(pulses - p0), 32'h0);
         ev(k[0], ns[k], nh[k]);
         chk(32'(pulses - p0), 32'h1);
         chk(32'(last_pulse), 32'(mask[k]));
         st = {21'h0, verd[k], 1'b1, 4'(nh[k]), 4'(ns[k])};
         rc(srm_pkg::IDX_STATUS, st, 2'h0);
         rc(srm_pkg::IDX_STATUS, st & 32'hfffffeff, 2'h0);
      end
      close_out();
   end
endmodule
